/* File: keypad_irq_pkg.sv */
package keypad_irq_pkg;

    localparam int REG_AW = 8;
    localparam int REG_DW = 8;

    // byte addresses of the register port
    localparam logic [REG_AW-1:0] ADDR_DEDKEY_HI     = 8'h04;
    localparam logic [REG_AW-1:0] ADDR_DEDKEY_LO     = 8'h05;
    localparam logic [REG_AW-1:0] ADDR_RAW_FLAGS     = 8'h06;
    localparam logic [REG_AW-1:0] ADDR_MASKED_FLAGS  = 8'h07;
    localparam logic [REG_DW-1:0] READ_UNMAPPED      = 8'h00;

    // dedicated key select fields and reset values
    localparam int             DEDKEY_W        = 16;
    localparam int             DEDKEY_ROW_LSB  = 10;
    localparam int             DEDKEY_COLH_LSB = 8;
    localparam logic [5:0]     DEDKEY_ROW_RST  = 6'h3F;
    localparam logic [1:0]     DEDKEY_COLH_RST = 2'h3;
    localparam logic [7:0]     DEDKEY_COLL_RST = 8'hFF;
    localparam logic [DEDKEY_W-1:0] DEDKEY_RST = {DEDKEY_ROW_RST, DEDKEY_COLH_RST,
                                                  DEDKEY_COLL_RST};

    // event buffer depth and occupancy counter width
    localparam int EVT_DEPTH   = 16;
    localparam int EVT_CNT_W   = 5;
    localparam int EVT_CNT_MAX = (1 << EVT_CNT_W) - 1;

    // flag layout: bit 3 overflow, bit 2 pending, bit 1 key lost, bit 0 scan change
    typedef struct packed {
        logic eventOverflow;
        logic eventPending;
        logic keyLost;
        logic scanChange;
    } kp_flags_t;

    localparam kp_flags_t FLAGS_RST = 4'h0;
    localparam int        FLAGS_W   = 4;

    typedef struct packed {
        logic              wrEn;
        logic              rdEn;
        logic [REG_AW-1:0] addr;
        logic [REG_DW-1:0] wrData;
    } reg_req_t;

    typedef struct packed {
        logic scanChangeDet;
        logic keyChangeDet;
        logic tooManyKeys;
        logic keyCodeEmptied;
        logic eventPush;
        logic eventPop;
    } key_events_t;

    typedef struct packed {
        logic [EVT_CNT_W-1:0] count;
        logic                 pending;
        logic                 overflowPulse;
    } occ_state_t;

    typedef struct packed {
        kp_flags_t          raw;
        logic [DEDKEY_W-1:0] dedCfg;
        logic [DEDKEY_W-1:0] dedEn;
        logic [REG_DW-1:0]  rdData;
        logic               irqReq;
        logic               fifoFlush;
    } ctrl_state_t;

endpackage : keypad_irq_pkg

/* File: event_occupancy.sv */
`timescale 1ns/1ps
module event_occupancy #(
    parameter int DEPTH = keypad_irq_pkg::EVT_DEPTH
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic push,
    input  wire logic pop,
    input  wire logic flush,
    output logic      pending,
    output logic      overflowPulse
);
    import keypad_irq_pkg::*;

    if (DEPTH < 1 || DEPTH > EVT_CNT_MAX) begin : g_bad_depth
        $error("event_occupancy: DEPTH out of range");
    end

    localparam logic [EVT_CNT_W-1:0] FULL_CNT = EVT_CNT_W'(DEPTH);
    localparam logic [EVT_CNT_W-1:0] ONE_CNT  = EVT_CNT_W'(1);
    localparam logic [EVT_CNT_W-1:0] ZERO_CNT = EVT_CNT_W'(0);

    occ_state_t st_r;
    occ_state_t st_nxt;

    always_comb begin
        st_nxt               = st_r;
        st_nxt.overflowPulse = 1'b0;
        if (flush) begin
            // a push in the flush cycle is kept
            st_nxt.count = push ? ONE_CNT : ZERO_CNT;
        end else if (push && !pop && st_r.count == FULL_CNT) begin
            // push at full is dropped, a push with a pop keeps the count
            st_nxt.overflowPulse = 1'b1;
        end else if (push && !(pop && st_r.count != ZERO_CNT)) begin
            st_nxt.count = st_r.count + ONE_CNT;
        end else if (!push && pop && st_r.count != ZERO_CNT) begin
            st_nxt.count = st_r.count - ONE_CNT;
        end
        st_nxt.pending = (st_nxt.count != ZERO_CNT);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pending       = st_r.pending;
    assign overflowPulse = st_r.overflowPulse;

endmodule : event_occupancy

/* File: keypad_dedkey_irq_status.sv */
// Summary of operation
// R01 - A read/write dedicated key select register sits at address 0x04 and picks per pin dedicated key or matrix/GPIO use.
// R02 - Select bits 15 to 10 govern row pins 7 down to 2 and reset to all ones.
// R03 - Select bits 9 and 8 govern column pins 11 and 10 and reset to ones.
// R04 - Select bits 7 to 0 govern column pins 9 down to 2 each on its own and reset to all ones.
// R05 - A select bit of zero makes its pin a dedicated key input, a one leaves it to GPIO or the matrix.
// R06 - A read-only raw flag register at address 0x06 shows the stored keypad flags in bits 3 to 0.
// R07 - Raw flag bit 3 sets when more than sixteen events overflow the event buffer.
// R08 - The raw and masked overflow flags hold until the host writes one to the event clear control.
// R09 - Raw flag bit 2 is set while any event code is buffered and clears when reads empty the buffer.
// R10 - Raw flag bit 1 sets on a new key change while the scan flag is set, or on more than four keys held.
// R11 - Raw flag bit 0 sets when a scan finds changed keys and clears when reads empty the key code registers.
// R12 - A read-only masked flag register at address 0x07 shows each raw flag gated by its mask bit.
// R13 - A mask bit of zero lets its flag reach the interrupt line, a one blocks it.
// R14 - The event clear control empties the event buffer and clears the pending and overflow flags.
// R15 - The scan clear control clears the scan and key-lost flags but leaves the key code registers.
// R16 - The interrupt request is high while any masked flag is set and low when all are clear.
`timescale 1ns/1ps
module keypad_dedkey_irq_status #(
    parameter int EVENT_DEPTH = keypad_irq_pkg::EVT_DEPTH
) (
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst,
    input  wire keypad_irq_pkg::reg_req_t              regReq,
    output logic [keypad_irq_pkg::REG_DW-1:0]          regRdData,
    input  wire keypad_irq_pkg::key_events_t           keyEvents,
    input  wire keypad_irq_pkg::kp_flags_t             keypadIrqMask,
    input  wire logic                                  eventClearStrobe,
    input  wire logic                                  scanClearStrobe,
    output logic [keypad_irq_pkg::DEDKEY_W-1:0]        dedicatedKeySelect,
    output logic [keypad_irq_pkg::DEDKEY_W-1:0]        dedicatedKeyEn,
    output logic                                       eventFifoFlush,
    output logic                                       irqReq
);
    import keypad_irq_pkg::*;

    // event buffer depth must fit the occupancy counter
    if (EVENT_DEPTH < 1 || EVENT_DEPTH > EVT_CNT_MAX) begin : g_bad_depth
        $error("keypad_dedkey_irq_status: EVENT_DEPTH out of range");
    end

    // select register must split into two register bytes
    if (DEDKEY_W != 2 * REG_DW || DEDKEY_COLH_LSB != REG_DW) begin : g_bad_split
        $error("keypad_dedkey_irq_status: select register does not split into bytes");
    end

    // flag nibble must fit a read byte
    if ($bits(kp_flags_t) != FLAGS_W || FLAGS_W > REG_DW) begin : g_bad_flags
        $error("keypad_dedkey_irq_status: flag layout does not fit a byte");
    end

    // row field sits right above the high column pair
    if (DEDKEY_ROW_LSB != DEDKEY_COLH_LSB + $bits(DEDKEY_COLH_RST)) begin : g_bad_fields
        $error("keypad_dedkey_irq_status: select fields do not line up");
    end

    // read decode needs four distinct addresses
    if (ADDR_DEDKEY_LO == ADDR_DEDKEY_HI || ADDR_RAW_FLAGS == ADDR_MASKED_FLAGS ||
        ADDR_RAW_FLAGS == ADDR_DEDKEY_HI || ADDR_RAW_FLAGS == ADDR_DEDKEY_LO ||
        ADDR_MASKED_FLAGS == ADDR_DEDKEY_HI ||
        ADDR_MASKED_FLAGS == ADDR_DEDKEY_LO) begin : g_bad_map
        $error("keypad_dedkey_irq_status: register addresses overlap");
    end

    // state register and occupancy taps
    ctrl_state_t st_r;
    ctrl_state_t st_nxt;
    logic        evtPending;
    logic        evtOverflow;

    // gate raw flags by mask, zero passes
    function automatic kp_flags_t mask_flags(
        input kp_flags_t raw,
        input kp_flags_t msk
    );
        mask_flags = raw & ~msk;
    endfunction : mask_flags

    // one byte access aimed at one address
    function automatic logic reg_hit(
        input logic              reqEn,
        input logic [REG_AW-1:0] addr,
        input logic [REG_AW-1:0] target
    );
        reg_hit = reqEn && (addr == target);
    endfunction : reg_hit

    // sticky flag, a set beats a clear
    function automatic logic sticky(
        input logic setEv,
        input logic held,
        input logic clearEv
    );
        sticky = setEv | (held & ~clearEv);
    endfunction : sticky

    // flag nibble widened to a register byte
    function automatic logic [REG_DW-1:0] flag_byte(
        input kp_flags_t flags
    );
        flag_byte = {{(REG_DW-FLAGS_W){1'b0}}, flags};
    endfunction : flag_byte

    // byte returned by a read, unmapped reads give zero
    function automatic logic [REG_DW-1:0] read_byte(
        input logic [REG_AW-1:0]   addr,
        input logic [DEDKEY_W-1:0] cfg,
        input kp_flags_t           raw,
        input kp_flags_t           msk
    );
        unique case (addr)
            ADDR_DEDKEY_HI: begin
                read_byte = cfg[DEDKEY_W-1:DEDKEY_COLH_LSB];
            end
            ADDR_DEDKEY_LO: begin
                read_byte = cfg[DEDKEY_COLH_LSB-1:0];
            end
            // R06 raw flags, upper bits zero
            ADDR_RAW_FLAGS: begin
                read_byte = flag_byte(raw);
            end
            // R12 masked flags
            ADDR_MASKED_FLAGS: begin
                read_byte = flag_byte(mask_flags(raw, msk));
            end
            default: begin
                read_byte = READ_UNMAPPED;
            end
        endcase
    endfunction : read_byte

    // R09 buffer occupancy
    // R14 flush empties it
    event_occupancy #(
        .DEPTH         (EVENT_DEPTH)
    ) u_occ (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .push          (keyEvents.eventPush),
        .pop           (keyEvents.eventPop),
        .flush         (eventClearStrobe),
        .pending       (evtPending),
        .overflowPulse (evtOverflow)
    );

    always_comb begin
        kp_flags_t rawN;
        kp_flags_t maskedN;
        logic      keyLostSet;
        logic      scanClear;
        rawN       = st_r.raw;
        maskedN    = FLAGS_RST;
        keyLostSet = 1'b0;
        scanClear  = 1'b0;
        st_nxt     = st_r;

        // R01 select register write
        if (reg_hit(regReq.wrEn, regReq.addr, ADDR_DEDKEY_HI)) begin
            // R02 row 7..2 bits
            st_nxt.dedCfg[DEDKEY_W-1:DEDKEY_ROW_LSB] =
                regReq.wrData[REG_DW-1:DEDKEY_ROW_LSB-DEDKEY_COLH_LSB];
            // R03 column 11..10 bits
            st_nxt.dedCfg[DEDKEY_ROW_LSB-1:DEDKEY_COLH_LSB] =
                regReq.wrData[DEDKEY_ROW_LSB-DEDKEY_COLH_LSB-1:0];
        end
        if (reg_hit(regReq.wrEn, regReq.addr, ADDR_DEDKEY_LO)) begin
            // R04 column 9..2 bits
            st_nxt.dedCfg[DEDKEY_COLH_LSB-1:0] = regReq.wrData;
        end
        // R05 zero selects dedicated key
        st_nxt.dedEn = ~st_nxt.dedCfg;

        // R11 scan flag, set wins
        scanClear       = scanClearStrobe | keyEvents.keyCodeEmptied;
        rawN.scanChange = sticky(keyEvents.scanChangeDet, st_r.raw.scanChange, scanClear);
        // R10 change over uncleared scan
        keyLostSet   = (keyEvents.keyChangeDet & st_r.raw.scanChange)
                       | keyEvents.tooManyKeys;
        // R15 scan clear
        rawN.keyLost = sticky(keyLostSet, st_r.raw.keyLost, scanClearStrobe);
        // R09 pending follows occupancy
        rawN.eventPending = evtPending;
        // R07 overflow sets
        // R08 holds until event clear
        rawN.eventOverflow = sticky(evtOverflow, st_r.raw.eventOverflow, eventClearStrobe);
        st_nxt.raw = rawN;

        // R14 flush pulse to the event buffer
        st_nxt.fifoFlush = eventClearStrobe;

        // R13 mask gating
        maskedN = mask_flags(rawN, keypadIrqMask);
        // R16 request while any masked flag set
        st_nxt.irqReq = |maskedN;

        // R06 raw flag read
        // R12 masked flag read
        if (regReq.rdEn) begin
            st_nxt.rdData = read_byte(regReq.addr,
                                      st_r.dedCfg,
                                      st_r.raw,
                                      keypadIrqMask);
        end
    end

    // one register stage for all state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r.raw       <= FLAGS_RST;
            st_r.dedCfg    <= DEDKEY_RST;
            st_r.dedEn     <= ~DEDKEY_RST;
            st_r.rdData    <= READ_UNMAPPED;
            st_r.irqReq    <= 1'b0;
            st_r.fifoFlush <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign regRdData          = st_r.rdData;
    assign dedicatedKeySelect = st_r.dedCfg;
    assign dedicatedKeyEn     = st_r.dedEn;
    assign eventFifoFlush     = st_r.fifoFlush;
    assign irqReq             = st_r.irqReq;

endmodule : keypad_dedkey_irq_status

/* File: keypad_host_model.sv */
`timescale 1ns/1ps
module keypad_host_model (
    input  wire logic                 clk_sys,
    output keypad_irq_pkg::reg_req_t  regReq
);
    import keypad_irq_pkg::*;
    initial regReq = '0;
    // one byte access, request held for one taking edge
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regReq <= '{w, !w, a, d};
        @(posedge clk_sys);
        regReq <= '0;
    endtask : acc
endmodule : keypad_host_model

/* File: keypad_dedkey_irq_status_assertions.sv */
`timescale 1ns/1ps
module keypad_dedkey_irq_status_assertions #(
    parameter int EVENT_DEPTH = 16
) (
    input wire logic                        clk_sys,
    input wire logic                        rst,
    input wire keypad_irq_pkg::reg_req_t    regReq,
    input wire logic [7:0]                  regRdData,
    input wire keypad_irq_pkg::key_events_t keyEvents,
    input wire keypad_irq_pkg::kp_flags_t   keypadIrqMask,
    input wire logic                        eventClearStrobe,
    input wire logic                        scanClearStrobe,
    input wire logic [15:0]                 dedicatedKeySelect,
    input wire logic [15:0]                 dedicatedKeyEn,
    input wire logic                        eventFifoFlush,
    input wire logic                        irqReq
);
    import keypad_irq_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence ovfOnly;
        keypadIrqMask == 4'h7 ##1 irqReq && keypadIrqMask == 4'h7 && !eventClearStrobe;
    endsequence
    dedkey_inverse_a: assert property (dedicatedKeyEn == ~dedicatedKeySelect)
        else $error("enable not inverse of select");
    hi_write_a: assert property (regReq.wrEn && regReq.addr == ADDR_DEDKEY_HI
        |=> dedicatedKeySelect[15:8] == $past(regReq.wrData)) else $error("high byte");
    lo_write_a: assert property (regReq.wrEn && regReq.addr == ADDR_DEDKEY_LO
        |=> dedicatedKeySelect[7:0] == $past(regReq.wrData)) else $error("low byte");
    raw_read_a: assert property (regReq.rdEn && regReq.addr == ADDR_RAW_FLAGS
        |=> regRdData[7:4] == 4'h0) else $error("raw upper bits");
    masked_read_a: assert property (regReq.rdEn && regReq.addr == ADDR_MASKED_FLAGS
        |=> (regRdData & {4'hF, 4'($past(keypadIrqMask))}) == 8'h00) else $error("mask read");
    flush_pulse_a: assert property (eventFifoFlush == $past(eventClearStrobe))
        else $error("flush pulse");
    scan_irq_a: assert property (keyEvents.scanChangeDet && !keypadIrqMask[0]
        |=> irqReq) else $error("scan irq");
    scan_clear_a: assert property (scanClearStrobe && keyEvents[5:3] == 3'b000
        && keypadIrqMask[3:2] == 2'b11 |=> !irqReq) else $error("scan clear");
    overflow_hold_a: assert property (ovfOnly |=> irqReq)
        else $error("overflow not held");
    key_lost_a: assert property (keyEvents.tooManyKeys && keypadIrqMask == 4'hD
        |=> irqReq) else $error("key lost irq");
endmodule : keypad_dedkey_irq_status_assertions
bind keypad_dedkey_irq_status keypad_dedkey_irq_status_assertions #(
    .EVENT_DEPTH(EVENT_DEPTH)) chk (.clk_sys, .rst, .regReq, .regRdData, .keyEvents,
    .keypadIrqMask, .eventClearStrobe, .scanClearStrobe, .dedicatedKeySelect,
    .dedicatedKeyEn, .eventFifoFlush, .irqReq);

/* File: keypad_dedkey_irq_status_tb.sv */
`timescale 1ns/1ps
module keypad_dedkey_irq_status_tb;
    import keypad_irq_pkg::*;
    localparam int DEPTH = 4;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    reg_req_t    regReq;
    logic [7:0]  regRdData;
    key_events_t keyEvents = '0;
    kp_flags_t   keypadIrqMask = '0;
    logic        eventClearStrobe = 1'b0;
    logic        scanClearStrobe = 1'b0;
    logic [15:0] dedicatedKeySelect;
    logic [15:0] dedicatedKeyEn;
    logic        eventFifoFlush;
    logic        irqReq;
    logic        rd1 = 1'b0;
    logic        rd2 = 1'b0;
    logic [31:0] seed = 32'h0000A886;
    logic [15:0] sel;
    logic [7:0]  expQ[$];
    int          errTotal = 0;
    int          totalChecks = 0;
    always #12.5 clk_sys = ~clk_sys;
    keypad_host_model host (.clk_sys, .regReq);
    keypad_dedkey_irq_status #(.EVENT_DEPTH(DEPTH)) dut (.clk_sys, .rst, .regReq, .regRdData,
        .keyEvents, .keypadIrqMask, .eventClearStrobe, .scanClearStrobe, .dedicatedKeySelect,
        .dedicatedKeyEn, .eventFifoFlush, .irqReq);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task check(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task close_out;
        if (errTotal == 0 && totalChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    task rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.acc(1'b0, a, 8'h00);
    endtask : rd
    task ev(input key_events_t e);
        @(posedge clk_sys);
        keyEvents <= e;
        @(posedge clk_sys);
        keyEvents <= '0;
    endtask : ev
    task strobe(input logic s, input logic e);
        @(posedge clk_sys);
        scanClearStrobe <= s;
        eventClearStrobe <= e;
        @(posedge clk_sys);
        scanClearStrobe <= 1'b0;
        eventClearStrobe <= 1'b0;
    endtask : strobe
    // read data lands one edge after the strobe is driven and is checked on the falling edge after the next rising edge
    always @(posedge clk_sys) begin
        rd1 <= regReq.rdEn;
        rd2 <= rd1;
    end
    always @(negedge clk_sys) begin
        if (rd2 === 1'b1) begin
            check(16'(regRdData), 16'(expQ.pop_front()));
        end
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        errTotal++;
        close_out;
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ADDR_DEDKEY_HI, 8'hFF);
        rd(ADDR_DEDKEY_LO, 8'hFF);
        check(dedicatedKeyEn, 16'h0000);
        check(dedicatedKeySelect, 16'hFFFF);
        rd(8'h0A, READ_UNMAPPED);
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            sel = seed[15:0];
            host.acc(1'b1, ADDR_DEDKEY_HI, sel[15:8]);
            host.acc(1'b1, ADDR_DEDKEY_LO, sel[7:0]);
            host.acc(1'b1, ADDR_RAW_FLAGS, 8'hFF);
            rd(ADDR_DEDKEY_HI, sel[15:8]);
            rd(ADDR_DEDKEY_LO, sel[7:0]);
            rd(ADDR_RAW_FLAGS, 8'h00);
            check(dedicatedKeyEn, ~sel);
            check(dedicatedKeySelect, sel);
        end
        keypadIrqMask <= 4'hC;
        ev(6'h20);
        ev(6'h10);
        rd(ADDR_RAW_FLAGS, 8'h03);
        rd(ADDR_MASKED_FLAGS, 8'h03);
        check(16'(irqReq), 16'h0001);
        keypadIrqMask <= 4'hF;
        rd(ADDR_MASKED_FLAGS, 8'h00);
        check(16'(irqReq), 16'h0000);
        keypadIrqMask <= 4'hC;
        strobe(1'b1, 1'b0);
        rd(ADDR_RAW_FLAGS, 8'h00);
        keypadIrqMask <= 4'hD;
        ev(6'h08);
        ev(6'h20);
        ev(6'h04);
        rd(ADDR_RAW_FLAGS, 8'h02);
        strobe(1'b1, 1'b0);
        keypadIrqMask <= 4'h7;
        repeat (DEPTH) ev(6'h02);
        rd(ADDR_RAW_FLAGS, 8'h04);
        ev(6'h02);
        rd(ADDR_RAW_FLAGS, 8'h0C);
        repeat (DEPTH + 1) ev(6'h01);
        rd(ADDR_RAW_FLAGS, 8'h08);
        check(16'(irqReq), 16'h0001);
        strobe(1'b0, 1'b1);
        rd(ADDR_RAW_FLAGS, 8'h00);
        repeat (3) @(posedge clk_sys);
        check(16'(expQ.size()), 16'h0000);
        close_out;
    end
endmodule : keypad_dedkey_irq_status_tb
